// >>> rtl/sor_top.v
// What this block does
// RULE1 - Substrate bias output follows source picked by select bits 2:0; codes 0-3 are generators.
// RULE2 - Code 4 bias mux a, 5 bias mux b, 7 shutter b/c mux; 6 invalid.
// RULE3 - Mechanical shutter output follows source picked by bits 5:3, same encoding.
// RULE4 - Flash strobe output follows source picked by bits 8:6, same encoding.
// RULE5 - Test output follows source picked by bits 11:9, same encoding.
// RULE6 - Each shutter generator owns five registers from 0x6D, 0x72, 0x77, 0x7C.
// RULE7 - Register 0xEB bits 15, 13, 12 steer the bias and shutter b/c muxes.
// RULE8 - Writing ones to the 8-bit trigger register launches the matching operations.
// RULE9 - Bit 0 all generators, 1-3 single generators, 4-5 bias generators, 6 exposure.
// RULE10 - Bit 7 starts readout; with exposure in same write, readout follows exposure. A lone bit 7 firing while a joint exposure runs is dropped.
// RULE11 - Select and trigger writes take effect at the next vertical sync.
// RULE12 - Reset clears all selects to generator a and all trigger bits.
`timescale 1ns/1ps
`include "sor_map.vh"

module sor_top #(
  parameter ADDR_W = `SOR_ADDR_W,
  parameter DATA_W = `SOR_DATA_W
) (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Serial register port
  input wire ser_clk,
  input wire ser_data,
  input wire ser_load_n,
  // Frame timing
  input wire vertical_sync,
  input wire exposure_done,
  // Internal sources
  input wire shutter_gen_a,
  input wire shutter_gen_b,
  input wire shutter_gen_c,
  input wire shutter_gen_d,
  input wire bias_mux_a,
  input wire bias_mux_b,
  input wire shutter_bc_mux,
  // Routed outputs
  output reg substrate_bias_out,
  output reg mechanical_shutter_out,
  output reg flash_strobe_out,
  output reg test_output,
  // Secondary mux steering
  output reg bias_mux_a_sel,
  output reg bias_mux_b_sel,
  output reg shutter_bc_sel,
  // Generator parameter writes
  output reg gen_param_wr,
  output reg [1:0] gen_param_idx,
  output reg [2:0] gen_param_word,
  output reg [DATA_W-1:0] gen_param_data,
  // Launch pulses
  output reg [3:0] shutter_gen_start,
  output reg [1:0] bias_gen_start,
  output reg exposure_start,
  output reg readout_start,
  // Status
  output reg [11:0] out_sel_active,
  output reg [7:0] trig_pending,
  output reg exposure_busy
);

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  // Sequencer states and decoded offsets
  localparam ST_IDLE = 2'b01;
  localparam ST_EXPOSE = 2'b10;
  localparam [ADDR_W-1:0] OFS_OUT_SEL = `SOR_OFS_OUT_SEL;
  localparam [ADDR_W-1:0] OFS_TRIG = `SOR_OFS_TRIG;
  localparam [ADDR_W-1:0] OFS_MUX = `SOR_OFS_MUX_CTRL;
  localparam [ADDR_W-1:0] GRP_LEN = `SOR_GEN_GRP_LEN;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg rst_meta_r;
  reg rst_sync_r;
  reg vd_prev_r;
  reg [11:0] sel_pend_r;
  reg [11:0] sel_act_r;
  reg [7:0] trig_pend_r;
  reg [2:0] mux_pend_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg gen_hit_nxt;
  reg [1:0] gen_idx_nxt;
  reg [2:0] gen_word_nxt;
  wire [ADDR_W-1:0] gen_base [0:3];
  wire wr_stb;
  wire [ADDR_W-1:0] wr_addr;
  wire [DATA_W-1:0] wr_data;
  wire rst_n;
  wire vd_rise;
  wire [3:0] gen_src;
  wire [3:0] route_nxt;
  wire [7:0] fire;

  // Reset copy, sync edge, source bus and launch mask
  assign rst_n = rst_sync_r;
  assign vd_rise = vertical_sync & ~vd_prev_r;
  assign gen_src = {shutter_gen_d, shutter_gen_c, shutter_gen_b, shutter_gen_a};
  assign fire = vd_rise ? trig_pend_r : 8'h00; // RULE11

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  // Two-stage release of the asynchronous reset
  // Internal reset lifts on the second edge after release
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------
  // Serial receiver
  // ----------------------------------------
  // Words arrive LSB first, address ahead of data
  sor_serial_rx #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_rx (
    .clock(clock),
    .rst_n(rst_n),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_load_n(ser_load_n),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data)
  );

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Pending copies catch writes, active copies change on sync
  // Select writes reach the pins only through the sync copy
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vd_prev_r <= 1'b0;
      sel_pend_r <= `SOR_OUT_SEL_RST; // RULE12
      sel_act_r <= `SOR_OUT_SEL_RST; // RULE12
      trig_pend_r <= `SOR_TRIG_RST; // RULE12
      mux_pend_r <= 3'h0;
      bias_mux_a_sel <= 1'b0;
      bias_mux_b_sel <= 1'b0;
      shutter_bc_sel <= 1'b0;
    end else begin
      vd_prev_r <= vertical_sync;
      if (vd_rise) begin
        sel_act_r <= sel_pend_r; // RULE11
        bias_mux_a_sel <= mux_pend_r[0]; // RULE7
        bias_mux_b_sel <= mux_pend_r[1]; // RULE7
        shutter_bc_sel <= mux_pend_r[2]; // RULE7
      end
      if (wr_stb && wr_addr == OFS_OUT_SEL) begin
        sel_pend_r <= wr_data[11:0];
      end
      if (wr_stb && wr_addr == OFS_MUX) begin
        mux_pend_r <= {wr_data[`SOR_MUX_BC_BIT], wr_data[`SOR_MUX_BIAS_B_BIT],
          wr_data[`SOR_MUX_BIAS_A_BIT]}; // RULE7
      end
      // A write in the launch cycle survives for the next sync
      if (wr_stb && wr_addr == OFS_TRIG) begin
        trig_pend_r <= (vd_rise ? 8'h00 : trig_pend_r) | wr_data[7:0]; // RULE8
      end else if (vd_rise) begin
        trig_pend_r <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Generator parameter decode
  // ----------------------------------------
  // Group bases of the four shutter generators
  // Plain wiring, so the bases stand from time zero
  assign gen_base[0] = `SOR_OFS_GEN_A; // RULE6
  assign gen_base[1] = `SOR_OFS_GEN_B; // RULE6
  assign gen_base[2] = `SOR_OFS_GEN_C; // RULE6
  assign gen_base[3] = `SOR_OFS_GEN_D; // RULE6

  // Find which group the write address falls in
  // Groups do not overlap, so at most one index matches
  integer g;
  always @* begin
    gen_hit_nxt = 1'b0;
    gen_idx_nxt = 2'h0;
    gen_word_nxt = 3'h0;
    for (g = 0; g < 4; g = g + 1) begin
      if (wr_addr >= gen_base[g] && wr_addr < gen_base[g] + GRP_LEN) begin
        gen_hit_nxt = wr_stb; // RULE6
        gen_idx_nxt = g[1:0];
        gen_word_nxt = wr_addr[2:0] - gen_base[g][2:0];
      end
    end
  end

  // Forward parameter words to the owning generator
  // Parameter words bypass the sync gate
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gen_param_wr <= 1'b0;
      gen_param_idx <= 2'h0;
      gen_param_word <= 3'h0;
      gen_param_data <= {DATA_W{1'b0}};
    end else begin
      gen_param_wr <= gen_hit_nxt;
      if (gen_hit_nxt) begin
        gen_param_idx <= gen_idx_nxt;
        gen_param_word <= gen_word_nxt;
        gen_param_data <= wr_data;
      end
    end
  end

  // ----------------------------------------
  // Output routing
  // ----------------------------------------
  // One selector per routed output, field i at bits 3i+2:3i
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_route
      sor_source_mux u_mux (
        .sel(sel_act_r[i*3 +: 3]),
        .gen(gen_src),
        .bias_a(bias_mux_a),
        .bias_b(bias_mux_b),
        .bc(shutter_bc_mux),
        .y(route_nxt[i])
      ); // RULE2
    end
  endgenerate

  // Register the routed levels
  // Routed levels lag their sources by one clock
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      substrate_bias_out <= 1'b0;
      mechanical_shutter_out <= 1'b0;
      flash_strobe_out <= 1'b0;
      test_output <= 1'b0;
    end else begin
      substrate_bias_out <= route_nxt[0]; // RULE1
      mechanical_shutter_out <= route_nxt[1]; // RULE3
      flash_strobe_out <= route_nxt[2]; // RULE4
      test_output <= route_nxt[3]; // RULE5
    end
  end

  // ----------------------------------------
  // Readout sequencing
  // ----------------------------------------
  // Hold readout back while a joint exposure runs
  // A lone readout fired while exposing is not queued
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (fire[`SOR_TRIG_EXPOSE] && fire[`SOR_TRIG_READOUT]) begin
          state_nxt = ST_EXPOSE; // RULE10
        end
      end
      ST_EXPOSE: begin
        if (exposure_done) begin
          state_nxt = ST_IDLE; // RULE10
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Launch pulses and status
  // ----------------------------------------
  // One-cycle launches at the sync edge, joint readout at exposure end
  // Status ports mirror the internal registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      shutter_gen_start <= 4'h0;
      bias_gen_start <= 2'h0;
      exposure_start <= 1'b0;
      readout_start <= 1'b0;
      out_sel_active <= `SOR_OUT_SEL_RST;
      trig_pending <= `SOR_TRIG_RST;
      exposure_busy <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shutter_gen_start <= fire[3:0] | {4{fire[`SOR_TRIG_ALL_GEN]}}; // RULE9
      bias_gen_start <= {fire[`SOR_TRIG_BIAS_B], fire[`SOR_TRIG_BIAS_A]}; // RULE9
      exposure_start <= fire[`SOR_TRIG_EXPOSE]; // RULE9
      readout_start <= (state_r == ST_IDLE && fire[`SOR_TRIG_READOUT] && !fire[`SOR_TRIG_EXPOSE]) ||
        (state_r == ST_EXPOSE && exposure_done); // RULE10
      out_sel_active <= sel_act_r;
      trig_pending <= trig_pend_r;
      exposure_busy <= (state_nxt == ST_EXPOSE);
    end
  end

endmodule // sor_top

// >>> rtl/sor_map.vh
`ifndef SOR_MAP_VH
`define SOR_MAP_VH

// ----------------------------------------
// Serial word layout
// ----------------------------------------
`define SOR_ADDR_W 8
`define SOR_DATA_W 24

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SOR_OFS_OUT_SEL 8'h60
`define SOR_OFS_TRIG 8'h61
`define SOR_OFS_MUX_CTRL 8'hEB
`define SOR_OFS_GEN_A 8'h6D
`define SOR_OFS_GEN_B 8'h72
`define SOR_OFS_GEN_C 8'h77
`define SOR_OFS_GEN_D 8'h7C
`define SOR_GEN_GRP_LEN 8'h05

// ----------------------------------------
// Output select fields
// ----------------------------------------
`define SOR_SEL_W 3
`define SOR_OUT_SEL_W 12
`define SOR_BIAS_SEL_LSB 0
`define SOR_MECH_SEL_LSB 3
`define SOR_STROBE_SEL_LSB 6
`define SOR_TEST_SEL_LSB 9
`define SOR_OUT_SEL_RST 12'h000

// ----------------------------------------
// Source codes
// ----------------------------------------
`define SOR_CODE_BIAS_A 3'h4
`define SOR_CODE_BIAS_B 3'h5
`define SOR_CODE_INVALID 3'h6
`define SOR_CODE_BC 3'h7

// ----------------------------------------
// Trigger register
// ----------------------------------------
`define SOR_TRIG_W 8
`define SOR_TRIG_RST 8'h00
`define SOR_TRIG_ALL_GEN 0
`define SOR_TRIG_BIAS_A 4
`define SOR_TRIG_BIAS_B 5
`define SOR_TRIG_EXPOSE 6
`define SOR_TRIG_READOUT 7

// ----------------------------------------
// Secondary mux control bits
// ----------------------------------------
`define SOR_MUX_BIAS_A_BIT 12
`define SOR_MUX_BIAS_B_BIT 13
`define SOR_MUX_BC_BIT 15

`endif

// >>> rtl/sor_source_mux.v
`timescale 1ns/1ps
`include "sor_map.vh"

// ----------------------------------------
// Eight-code source selector for one routed output
// ----------------------------------------
module sor_source_mux (
  // Select code
  input wire [2:0] sel,
  // Candidate sources
  input wire [3:0] gen,
  input wire bias_a,
  input wire bias_b,
  input wire bc,
  // Chosen level
  output reg y
);

  // Codes 0..3 pick a shutter generator, 4/5/7 the muxes
  always @* begin
    case (sel)
      3'h0, 3'h1, 3'h2, 3'h3: y = gen[sel[1:0]];
      `SOR_CODE_BIAS_A: y = bias_a;
      `SOR_CODE_BIAS_B: y = bias_b;
      `SOR_CODE_BC: y = bc;
      default: y = 1'b0; // Invalid code parks low
    endcase
  end

endmodule // sor_source_mux

// >>> rtl/sor_serial_rx.v
`timescale 1ns/1ps
`include "sor_map.vh"

// ----------------------------------------
// Three-wire serial write receiver, address then data, LSB first
// ----------------------------------------
module sor_serial_rx #(
  parameter ADDR_W = `SOR_ADDR_W,
  parameter DATA_W = `SOR_DATA_W
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Serial pins
  input wire ser_clk,
  input wire ser_data,
  input wire ser_load_n,
  // Decoded write
  output reg wr_stb,
  output reg [ADDR_W-1:0] wr_addr,
  output reg [DATA_W-1:0] wr_data
);

  localparam TOT_W = ADDR_W + DATA_W;
  localparam [7:0] TOT_CNT = TOT_W;

  reg sck_prev_r;
  reg [TOT_W-1:0] shift_r;
  reg [7:0] cnt_r;
  wire sck_rise;

  assign sck_rise = ser_clk & ~sck_prev_r;

  // Shift bits while load is low, strobe on the last bit
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_r <= 1'b0;
      shift_r <= {TOT_W{1'b0}};
      cnt_r <= 8'h00;
      wr_stb <= 1'b0;
      wr_addr <= {ADDR_W{1'b0}};
      wr_data <= {DATA_W{1'b0}};
    end else begin
      sck_prev_r <= ser_clk;
      wr_stb <= 1'b0;
      if (ser_load_n) begin
        cnt_r <= 8'h00; // Frame ends, partial words dropped
      end else if (sck_rise && cnt_r < TOT_CNT) begin
        shift_r <= {ser_data, shift_r[TOT_W-1:1]};
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == TOT_CNT - 8'h01) begin
          wr_stb <= 1'b1;
          wr_addr <= shift_r[ADDR_W:1]; // Address bits, oldest at bit 1
          wr_data <= {ser_data, shift_r[TOT_W-1:ADDR_W+1]};
        end
      end
    end
  end

endmodule // sor_serial_rx

// >>> testbench/sor_top_assertions.sv
`timescale 1ns/1ps
module sor_top_assertions (
  // Clock, reset, frame timing
  input wire clock,
  input wire reset_n,
  input wire vertical_sync,
  input wire exposure_done,
  // Sources
  input wire shutter_gen_a,
  input wire shutter_gen_b,
  input wire shutter_gen_c,
  input wire shutter_gen_d,
  input wire bias_mux_a,
  input wire bias_mux_b,
  input wire shutter_bc_mux,
  // Routed and steering outputs
  input wire substrate_bias_out,
  input wire mechanical_shutter_out,
  input wire flash_strobe_out,
  input wire test_output,
  input wire bias_mux_a_sel,
  input wire bias_mux_b_sel,
  input wire shutter_bc_sel,
  // Writes, launches, status
  input wire gen_param_wr,
  input wire [2:0] gen_param_word,
  input wire [3:0] shutter_gen_start,
  input wire [1:0] bias_gen_start,
  input wire exposure_start,
  input wire readout_start,
  input wire [11:0] out_sel_active,
  input wire [7:0] trig_pending,
  input wire exposure_busy
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  reg [2:0] age_r;
  reg [3:0] vs_r;
  wire ok = age_r[2];
  wire rise = |(vs_r[2:0] & ~vs_r[3:1]);
  wire [6:0] src = {shutter_bc_mux, bias_mux_b, bias_mux_a, shutter_gen_d, shutter_gen_c, shutter_gen_b, shutter_gen_a};

  // Settle age after reset and sync history
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      age_r <= 3'h0;
      vs_r <= 4'h0;
    end else begin
      age_r <= ok ? age_r : age_r + 3'h1;
      vs_r <= {vs_r[2:0], vertical_sync};
    end
  end

  // Expected routed level for one select code
  function route(input [2:0] s, input [6:0] v);
    route = (s == 3'h6) ? 1'b0 : (s == 3'h7) ? v[6] : v[s];
  endfunction

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_bias; ok |-> substrate_bias_out == route(out_sel_active[2:0], $past(src)); endproperty
  a_bias: assert property (p_bias) else $error("bias output wrong");
  property p_mech; ok |-> mechanical_shutter_out == route(out_sel_active[5:3], $past(src)); endproperty
  a_mech: assert property (p_mech) else $error("mech output wrong");
  property p_strobe; ok |-> flash_strobe_out == route(out_sel_active[8:6], $past(src)); endproperty
  a_strobe: assert property (p_strobe) else $error("strobe output wrong");
  property p_test; ok |-> test_output == route(out_sel_active[11:9], $past(src)); endproperty
  a_test: assert property (p_test) else $error("test output wrong");
  property p_code6; ok && out_sel_active[5:3] == 3'h6 |-> !mechanical_shutter_out; endproperty
  a_code6: assert property (p_code6) else $error("invalid code not low");
  property p_sel_hold; ok && $changed(out_sel_active) |-> rise; endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select changed off sync");
  property p_mux_hold; ok && $changed({bias_mux_a_sel, bias_mux_b_sel, shutter_bc_sel}) |-> rise; endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("mux steering changed off sync");
  property p_start; ok && (|{shutter_gen_start, bias_gen_start, exposure_start}) |-> rise; endproperty
  a_start: assert property (p_start) else $error("launch off sync");
  property p_read; ok && exposure_busy && $rose(exposure_done) |-> ##[1:3] readout_start; endproperty
  a_read: assert property (p_read) else $error("readout late");
  property p_no_read;
    exposure_busy && !exposure_done && !$past(exposure_done) && !$past(exposure_done, 2) |-> !readout_start;
  endproperty
  a_no_read: assert property (p_no_read) else $error("readout before exposure end");
  property p_reset; !ok |-> out_sel_active == 12'h000 && trig_pending == 8'h00 && !exposure_busy; endproperty
  a_reset: assert property (p_reset) else $error("state not clear after reset");
  property p_word; gen_param_wr |-> gen_param_word <= 3'h4; endproperty
  a_word: assert property (p_word) else $error("parameter word out of group");
  property p_pulse; exposure_start |=> !exposure_start; endproperty
  a_pulse: assert property (p_pulse) else $error("exposure start not a pulse");

  // Main scenarios reached
  c_exp: cover property (exposure_start);
  c_read: cover property (readout_start);
  c_param: cover property (gen_param_wr);
endmodule // sor_top_assertions

bind sor_top sor_top_assertions u_chk (.*);

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  reg clock = 0, reset_n = 0, ser_clk = 0, ser_data = 0, ser_load_n = 1;
  reg vertical_sync = 0, exposure_done = 0;
  reg shutter_gen_a = 0, shutter_gen_b = 0, shutter_gen_c = 0, shutter_gen_d = 0;
  reg bias_mux_a = 0, bias_mux_b = 0, shutter_bc_mux = 0;
  wire substrate_bias_out, mechanical_shutter_out, flash_strobe_out, test_output;
  wire bias_mux_a_sel, bias_mux_b_sel, shutter_bc_sel, gen_param_wr;
  wire exposure_start, readout_start, exposure_busy;
  wire [1:0] gen_param_idx, bias_gen_start;
  wire [2:0] gen_param_word;
  wire [23:0] gen_param_data;
  wire [3:0] shutter_gen_start;
  wire [11:0] out_sel_active;
  wire [7:0] trig_pending;
  integer mismatches = 0, comparisons = 0, cyc = 0;
  reg [31:0] seed = 32'h3A92;
  reg [7:0] hits = 8'h00;
  reg vs_prev_r = 1'b0;
  reg [28:0] pw = 29'h0;

  sor_top DUT (.*);

  // Clock
  initial forever #10 clock = ~clock;

  // Launch pulse capture cleared at each sync edge, parameter capture, timeout
  always @(posedge clock) begin
    cyc <= cyc + 1;
    vs_prev_r <= vertical_sync;
    hits <= (vertical_sync && !vs_prev_r) ? 8'h00 :
      hits | {readout_start, exposure_start, bias_gen_start, shutter_gen_start};
    if (gen_param_wr) pw <= {gen_param_idx, gen_param_word, gen_param_data};
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] rnd(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      rnd = x ^ (x << 5);
    end
  endfunction

  function route(input [2:0] s, input [6:0] v);
    route = (s == 3'h6) ? 1'b0 : (s == 3'h7) ? v[6] : v[s];
  endfunction

  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask

  task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0s expected %0h seen %0h", nm, exp, got);
      end
    end
  endtask

  // One serial word, address then data, LSB first
  task wr(input [7:0] a, input [23:0] d);
    integer i;
    reg [31:0] w;
    begin
      w = {d, a};
      @(posedge clock);
      ser_load_n <= 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        ser_data <= w[i];
        tick(3);
        ser_clk <= 1'b1;
        tick(3);
        ser_clk <= 1'b0;
      end
      tick(3);
      ser_load_n <= 1'b1;
      tick(4);
    end
  endtask

  // Frame boundary with launch capture cleared
  task vsync;
    begin
      @(posedge clock);
      vertical_sync <= 1'b1;
      tick(2);
      vertical_sync <= 1'b0;
      tick(4);
    end
  endtask

  task wrap_up;
    begin
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin : main
    integer i, k;
    reg [11:0] s, p;
    reg [6:0] v;
    p = 12'h000;
    tick(20);
    reset_n <= 1'b1;
    tick(4);
    chk("sel", 0, out_sel_active);
    chk("trig", 0, trig_pending);
    // Every code through every field, random source levels
    for (i = 0; i < 8; i = i + 1) begin
      s = {i[2:0] + 3'h3, i[2:0] + 3'h2, i[2:0] + 3'h1, i[2:0]};
      wr(8'h60, {12'h000, s});
      chk("hold", p, out_sel_active);
      vsync;
      chk("sel", s, out_sel_active);
      for (k = 0; k < 8; k = k + 1) begin
        tick(1);
        seed = rnd(seed);
        v = seed[6:0];
        {shutter_bc_mux, bias_mux_b, bias_mux_a, shutter_gen_d, shutter_gen_c, shutter_gen_b, shutter_gen_a} <= v;
        tick(1);
        #1;
        chk("bias", route(s[2:0], v), substrate_bias_out);
        chk("mech", route(s[5:3], v), mechanical_shutter_out);
        chk("strobe", route(s[8:6], v), flash_strobe_out);
        chk("test", route(s[11:9], v), test_output);
      end
      p = s;
    end
    // Unmapped address leaves selects alone
    wr(8'h33, 24'h000FFF);
    vsync;
    chk("unmap", p, out_sel_active);
    // Secondary mux steering
    wr(8'hEB, 24'h009000);
    chk("mux0", 0, {bias_mux_a_sel, bias_mux_b_sel, shutter_bc_sel});
    vsync;
    chk("mux", 3'h5, {bias_mux_a_sel, bias_mux_b_sel, shutter_bc_sel});
    // Generator parameter groups, word i of groups 0-2, last word of group 3
    for (i = 0; i < 4; i = i + 1) begin
      seed = rnd(seed);
      k = (i == 3) ? 4 : i;
      wr(8'h6D + 5 * i + k, seed[23:0]);
      chk("param", {i[1:0], k[2:0], seed[23:0]}, pw);
    end
    // Each trigger bit alone
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h61, 24'h000001 << i);
      chk("pend", 8'h01 << i, trig_pending);
      vsync;
      chk("start", (i == 0) ? 8'h0F : 8'h01 << i, hits);
      chk("clear", 0, trig_pending);
      exposure_done <= 1'b1;
      tick(1);
      exposure_done <= 1'b0;
      tick(3);
    end
    // Exposure and readout in one write
    wr(8'h61, 24'h0000C0);
    vsync;
    tick(4);
    chk("joint", 8'h40, hits);
    chk("busy", 1, exposure_busy);
    exposure_done <= 1'b1;
    tick(1);
    exposure_done <= 1'b0;
    tick(4);
    chk("joint", 8'hC0, hits);
    chk("busy", 0, exposure_busy);
    wrap_up;
  end
endmodule // tb_top
